// ===== core/rsec_apb_slave.sv
// apb slave front end, one wait-free access phase per transfer
`timescale 1ns/1ps
`default_nettype none
module rsec_apb_slave
  import rsec_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  rsec_reg_if.slave        regs
);
  rsec_apb_state_type state_reg;
  rsec_apb_state_type state_next;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  logic               err_reg;
  logic               err_next;
  logic               setup;
  logic               access_err;

  assign setup       = psel && !penable;
  // refused transfers read as zero, so a bad address leaks no register contents
  assign access_err  = !regs.hit || (paddr[1:0] != 2'h0) || (paddr[11:10] != 2'h0);
  assign regs.idx    = paddr[9:2];
  assign regs.wdata  = pwdata[7:0];
  assign regs.rd_en  = setup && !pwrite;
  // unaligned or out of range addresses are not mapped
  assign regs.wr_en  = (state_reg == RSEC_ST_ACCESS) && psel && penable && pwrite && !err_reg;

  always_comb
  begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    case (state_reg)
      RSEC_ST_IDLE:
      begin
        if (setup)
        begin
          state_next = RSEC_ST_ACCESS;
          rdata_next = (pwrite || access_err) ? 8'h00 : regs.rdata;
          err_next   = access_err;
        end
      end
      RSEC_ST_ACCESS:
      begin
        state_next = RSEC_ST_IDLE;
      end
      default:
      begin
        state_next = RSEC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= RSEC_ST_IDLE;
      rdata_reg <= 8'h00;
      err_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata  = {24'h000000, rdata_reg};
  assign pready  = (state_reg == RSEC_ST_ACCESS);
  assign pslverr = (state_reg == RSEC_ST_ACCESS) && err_reg;
endmodule : rsec_apb_slave
`default_nettype wire

// ===== core/rsec_event_counter.sv
// saturating event counter with a pulse when it reaches full scale
`timescale 1ns/1ps
`default_nettype none
module rsec_event_counter
  import rsec_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             inc,
  output logic [WIDTH-1:0]      count,
  output logic                  sat_pulse
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             sat_reg;
  logic             sat_next;

  // saturate rather than wrap: a wrapped count would hide a burst of errors
  always_comb
  begin
    count_next = count_reg;
    sat_next   = 1'b0;
    if (inc && (count_reg != {WIDTH{1'b1}}))
    begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      sat_next   = (count_next == {WIDTH{1'b1}});
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      count_reg <= '0;
      sat_reg   <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      sat_reg   <= sat_next;
    end
  end

  assign count     = count_reg;
  assign sat_pulse = sat_reg;
endmodule : rsec_event_counter
`default_nettype wire

// ===== core/rsec_pkg.sv
// types shared by the receive signaling and error counter bank
package rsec_pkg;

  typedef enum logic [1:0] {
    RSEC_ST_IDLE   = 2'b01,
    RSEC_ST_ACCESS = 2'b10
  } rsec_apb_state_type;

  typedef logic [7:0] rsec_byte_type;
  typedef logic [3:0] rsec_nibble_type;

endpackage : rsec_pkg

// ===== core/rsec_reg_if.sv
// register access carrier between bus slave and register bank
`timescale 1ns/1ps
`default_nettype none
interface rsec_reg_if;
  logic [7:0] idx;
  logic       rd_en;
  logic       wr_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;

  modport slave (output idx, output rd_en, output wr_en, output wdata, input rdata, input hit);
  modport bank  (input idx, input rd_en, input wr_en, input wdata, output rdata, output hit);
endinterface : rsec_reg_if
`default_nettype wire

// ===== core/rsec_regs.svh
// register offsets, field positions, reset values of the receive signaling and error counter bank
// Notes on behaviour
// - with extended superframe framing, capture A, B, C and D bits of each channel
// - with D4 superframe framing, copy A and B into the C and D positions
// - signaling registers freeze during loss of frame, keeping the last captured values
// - 16-bit line violation count, high byte at 050h, low byte at 051h
// - 16-bit path violation count, high byte at 052h, low byte at 053h
// - 16-bit out of sync frame count, bits 15:8 high register, bits 7:0 at 055h
// - 16-bit E-bit count in E1 only, high byte 056h, low byte 057h
// - selected timeslot byte at 060h, first received bit in bit 7
// - read-only receive firmware revision at 061h, writes have no effect
`ifndef RSEC_REGS_SVH
`define RSEC_REGS_SVH

// register indices; byte address on the bus is four times the index
`define RSEC_IDX_SIG_FIRST   8'h40
`define RSEC_IDX_SIG_LAST    8'h4f
`define RSEC_IDX_LCV_HIGH    8'h50
`define RSEC_IDX_LCV_LOW     8'h51
`define RSEC_IDX_PCV_HIGH    8'h52
`define RSEC_IDX_PCV_LOW     8'h53
`define RSEC_IDX_OOS_HIGH    8'h54
`define RSEC_IDX_OOS_LOW     8'h55
`define RSEC_IDX_EBIT_HIGH   8'h56
`define RSEC_IDX_EBIT_LOW    8'h57
`define RSEC_IDX_MON_BYTE    8'h60
`define RSEC_IDX_FW_REV      8'h61
`define RSEC_IDX_MON_SELECT  8'h70
`define RSEC_IDX_INT_STATUS  8'h71
`define RSEC_IDX_INT_CLEAR   8'h72
`define RSEC_IDX_INT_ENABLE  8'h73

// interrupt status / clear / enable bit positions
`define RSEC_INT_LCV_SAT     0
`define RSEC_INT_PCV_SAT     1
`define RSEC_INT_OOS_SAT     2
`define RSEC_INT_EBIT_SAT    3
`define RSEC_INT_SIG_CHANGE  4
`define RSEC_INT_FRAME_LOSS  5
`define RSEC_INT_WIDTH       6

// reset values
`define RSEC_RST_COUNT       16'h0000
`define RSEC_RST_BYTE        8'h00
`define RSEC_RST_NIBBLE      4'h0
`define RSEC_RST_MON_SELECT  5'h00
`define RSEC_RST_INT         6'h00

`endif

// ===== core/rsec_top.sv
// receive signaling snapshot, error counters and timeslot monitor behind apb
`timescale 1ns/1ps
`default_nettype none
`include "rsec_regs.svh"
module rsec_top
  import rsec_pkg::*;
#(
  parameter logic [7:0] FW_REVISION = 8'h5a, // arbitrary value
  parameter int         COUNT_WIDTH = 16
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        e1_mode,
  input  wire logic        esf_mode,
  input  wire logic        out_of_frame,
  input  wire logic        frame_tick,
  input  wire logic        line_violation,
  input  wire logic        path_violation,
  input  wire logic        ebit_error,
  input  wire logic        sig_valid,
  input  wire logic [4:0]  sig_channel,
  input  wire logic [3:0]  sig_bits,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  input  wire logic [2:0]  rx_bit_index,
  input  wire logic [4:0]  rx_timeslot
);
  rsec_reg_if regs ();

  logic [COUNT_WIDTH-1:0] lcv_count;
  logic [COUNT_WIDTH-1:0] pcv_count;
  logic [COUNT_WIDTH-1:0] oos_count;
  logic [COUNT_WIDTH-1:0] ebit_count;
  logic                   lcv_sat;
  logic                   pcv_sat;
  logic                   oos_sat;
  logic                   ebit_sat;
  // byte-pair views of the counts
  logic [15:0]            lcv_word;
  logic [15:0]            pcv_word;
  logic [15:0]            oos_word;
  logic [15:0]            ebit_word;

  rsec_nibble_type sig_reg [0:31];
  rsec_nibble_type sig_next [0:31];
  rsec_nibble_type sig_nibble;
  logic            sig_capture;
  logic            sig_changed;

  logic [7:0]      mon_shift_reg;
  logic [7:0]      mon_shift_next;
  rsec_byte_type   mon_byte_reg;
  rsec_byte_type   mon_byte_next;
  logic [4:0]      mon_select_reg;
  logic [4:0]      mon_select_next;

  logic            frame_loss_prev_reg;
  logic            frame_loss_prev_next;
  logic [`RSEC_INT_WIDTH-1:0] int_status_reg;
  logic [`RSEC_INT_WIDTH-1:0] int_status_next;
  logic [`RSEC_INT_WIDTH-1:0] int_enable_reg;
  logic [`RSEC_INT_WIDTH-1:0] int_enable_next;
  logic [`RSEC_INT_WIDTH-1:0] int_events;

  logic [3:0]      sig_byte_idx;
  logic [4:0]      sig_low_ch;

  rsec_apb_slave u_apb (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regs.slave)
  );

  // line violations counted on every flagged bit
  rsec_event_counter #(.WIDTH(COUNT_WIDTH)) u_lcv (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .inc       (line_violation),
    .count     (lcv_count),
    .sat_pulse (lcv_sat)
  );

  rsec_event_counter #(.WIDTH(COUNT_WIDTH)) u_pcv (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .inc       (path_violation),
    .count     (pcv_count),
    .sat_pulse (pcv_sat)
  );

  // one count per frame spent out of frame
  rsec_event_counter #(.WIDTH(COUNT_WIDTH)) u_oos (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .inc       (frame_tick && out_of_frame),
    .count     (oos_count),
    .sat_pulse (oos_sat)
  );

  // e-bit errors only count in E1 operation
  rsec_event_counter #(.WIDTH(COUNT_WIDTH)) u_ebit (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .inc       (ebit_error && e1_mode),
    .count     (ebit_count),
    .sat_pulse (ebit_sat)
  );

  // signaling capture
  always_comb
  begin
    sig_nibble = sig_bits;
    // D4 has only A and B, mirrored into C and D
    if (!e1_mode && !esf_mode)
    begin
      sig_nibble = {sig_bits[3:2], sig_bits[3:2]};
    end
  end

  // no capture while frame sync is lost
  // index 31 names no channel; dropped rather than stored
  assign sig_capture = sig_valid && !out_of_frame && (sig_channel != 5'h1f);
  assign sig_changed = sig_capture && (sig_reg[sig_channel] != sig_nibble);

  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      sig_next[i] = sig_reg[i];
    end
    // full A to D nibble stored per channel
    if (sig_capture)
    begin
      sig_next[sig_channel] = sig_nibble;
    end
  end

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (sys_rst)
      begin
        sig_reg[i] <= `RSEC_RST_NIBBLE;
      end
      else
      begin
        sig_reg[i] <= sig_next[i];
      end
    end
  end

  // timeslot monitor
  always_comb
  begin
    mon_shift_next = mon_shift_reg;
    mon_byte_next  = mon_byte_reg;
    if (rx_bit_valid)
    begin
      mon_shift_next = {mon_shift_reg[6:0], rx_bit};
      // first received bit ends up in bit 7
      if ((rx_bit_index == 3'h7) && (rx_timeslot == mon_select_reg))
      begin
        mon_byte_next = {mon_shift_reg[6:0], rx_bit};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mon_shift_reg <= `RSEC_RST_BYTE;
      mon_byte_reg  <= `RSEC_RST_BYTE;
    end
    else
    begin
      mon_shift_reg <= mon_shift_next;
      mon_byte_reg  <= mon_byte_next;
    end
  end

  // control registers written by software
  always_comb
  begin
    mon_select_next = mon_select_reg;
    int_enable_next = int_enable_reg;
    // select picks the timeslot the monitor keeps
    if (regs.wr_en && (regs.idx == `RSEC_IDX_MON_SELECT))
    begin
      mon_select_next = regs.wdata[4:0];
    end
    if (regs.wr_en && (regs.idx == `RSEC_IDX_INT_ENABLE))
    begin
      int_enable_next = regs.wdata[`RSEC_INT_WIDTH-1:0];
    end
  end

  // select and enable clear on reset: timeslot 0 monitored, nothing enabled
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mon_select_reg <= `RSEC_RST_MON_SELECT;
      int_enable_reg <= `RSEC_RST_INT;
    end
    else
    begin
      mon_select_reg <= mon_select_next;
      int_enable_reg <= int_enable_next;
    end
  end

  // reset value matches the idle level of the pin, so no false edge after reset
  always_comb
  begin
    frame_loss_prev_next = out_of_frame;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      frame_loss_prev_reg <= 1'b0;
    end
    else
    begin
      frame_loss_prev_reg <= frame_loss_prev_next;
    end
  end

  // interrupt sources, one pulse per event
  always_comb
  begin
    int_events = '0;
    int_events[`RSEC_INT_LCV_SAT]    = lcv_sat;
    int_events[`RSEC_INT_PCV_SAT]    = pcv_sat;
    int_events[`RSEC_INT_OOS_SAT]    = oos_sat;
    int_events[`RSEC_INT_EBIT_SAT]   = ebit_sat;
    int_events[`RSEC_INT_SIG_CHANGE] = sig_changed;
    int_events[`RSEC_INT_FRAME_LOSS] = out_of_frame && !frame_loss_prev_reg;
  end

  // interrupt status: a new event wins over a clear in the same cycle
  always_comb
  begin
    int_status_next = int_status_reg;
    if (regs.wr_en && (regs.idx == `RSEC_IDX_INT_CLEAR))
    begin
      int_status_next = int_status_reg & ~regs.wdata[`RSEC_INT_WIDTH-1:0];
    end
    int_status_next = int_status_next | int_events;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      int_status_reg <= `RSEC_RST_INT;
    end
    else
    begin
      int_status_reg <= int_status_next;
    end
  end

  assign irq = |(int_status_reg & int_enable_reg);

  // cut or widened on purpose, so a narrower count width still fits the byte pairs
  assign lcv_word  = 16'(lcv_count);
  assign pcv_word  = 16'(pcv_count);
  assign oos_word  = 16'(oos_count);
  assign ebit_word = 16'(ebit_count);

  // read decode
  assign sig_byte_idx = regs.idx[3:0];
  assign sig_low_ch   = {1'b0, sig_byte_idx} + 5'h0f;

  always_comb
  begin
    regs.rdata = 8'h00;
    regs.hit   = 1'b1;
    if ((regs.idx >= `RSEC_IDX_SIG_FIRST) && (regs.idx <= `RSEC_IDX_SIG_LAST))
    begin
      // first byte is zeros over spare bits, then channel pairs
      if (sig_byte_idx == 4'h0)
      begin
        regs.rdata = {4'h0, sig_reg[0]};
      end
      else
      begin
        regs.rdata = {sig_reg[{1'b0, sig_byte_idx}], sig_reg[sig_low_ch]};
      end
    end
    else
    begin
      case (regs.idx)
        // counts are not latched: reading high then low can tear while counting
        // line count bytes
        `RSEC_IDX_LCV_HIGH:   regs.rdata = lcv_word[15:8];
        `RSEC_IDX_LCV_LOW:    regs.rdata = lcv_word[7:0];
        `RSEC_IDX_PCV_HIGH:   regs.rdata = pcv_word[15:8];
        `RSEC_IDX_PCV_LOW:    regs.rdata = pcv_word[7:0];
        `RSEC_IDX_OOS_HIGH:   regs.rdata = oos_word[15:8];
        `RSEC_IDX_OOS_LOW:    regs.rdata = oos_word[7:0];
        `RSEC_IDX_EBIT_HIGH:  regs.rdata = ebit_word[15:8];
        `RSEC_IDX_EBIT_LOW:   regs.rdata = ebit_word[7:0];
        `RSEC_IDX_MON_BYTE:   regs.rdata = mon_byte_reg;
        `RSEC_IDX_FW_REV:     regs.rdata = FW_REVISION;
        `RSEC_IDX_MON_SELECT: regs.rdata = {3'h0, mon_select_reg};
        `RSEC_IDX_INT_STATUS: regs.rdata = {2'h0, int_status_reg};
        `RSEC_IDX_INT_CLEAR:  regs.rdata = 8'h00;
        `RSEC_IDX_INT_ENABLE: regs.rdata = {2'h0, int_enable_reg};
        default:              regs.hit   = 1'b0;
      endcase
    end
  end
endmodule : rsec_top
`default_nettype wire

// ===== verification/rsec_top_sva.sv
// concurrent checks on the bus side of the signaling and counter bank
`timescale 1ns/1ps
`default_nettype none
module rsec_top_sva
#(
  parameter logic [7:0] FW_REVISION = 8'h5a,
  parameter int         COUNT_WIDTH = 16
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic setup;
  logic mapped_addr;
  assign setup = psel && !penable;
  assign mapped_addr = (paddr[11:8] == 4'h1) && (paddr[7:2] < 6'h18) && (paddr[1:0] == 2'h0);

  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready in the cycle after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_byte_data_only: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_fw_rev_value: assert property (setup && !pwrite && paddr == 12'h184 |=> prdata[7:0] == FW_REVISION)
    else $error("firmware revision read wrong");
  a_err_unaligned: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  a_err_out_range: assert property (setup && paddr[11:10] != 2'h0 |=> pslverr)
    else $error("out of range access not refused");
  a_mapped_no_err: assert property (setup && mapped_addr |=> !pslverr)
    else $error("mapped access refused");
  a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0) sys_rst |=> !pready && !irq && !pslverr)
    else $error("outputs active after reset");

  cover property (pslverr);
  cover property ($rose(irq));
  cover property (pready && !pwrite && prdata[7:0] != 8'h00);
endmodule : rsec_top_sva

bind rsec_top rsec_top_sva #(.FW_REVISION(FW_REVISION), .COUNT_WIDTH(COUNT_WIDTH)) i_rsec_top_sva (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ===== verification/rsec_top_test.sv
// self-checking bench for the signaling and counter bank
`timescale 1ns/1ps
`default_nettype none
module rsec_top_test;
  localparam logic [7:0] FW_REV = 8'h3c; // arbitrary value
  logic        mclk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        e1_mode;
  logic        esf_mode;
  logic        out_of_frame;
  logic [3:0]  ev;
  logic        sig_valid;
  logic [4:0]  sig_channel;
  logic [3:0]  sig_bits;
  logic        rx_bit_valid;
  logic        rx_bit;
  logic [2:0]  rx_bit_index;
  logic [4:0]  rx_timeslot;
  logic [31:0] q;
  logic        e;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  rsec_top #(.FW_REVISION(FW_REV)) i_rsec_top (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .e1_mode(e1_mode),
    .esf_mode(esf_mode), .out_of_frame(out_of_frame), .frame_tick(ev[0]), .line_violation(ev[3]),
    .path_violation(ev[2]), .ebit_error(ev[1]), .sig_valid(sig_valid), .sig_channel(sig_channel),
    .sig_bits(sig_bits), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_bit_index(rx_bit_index),
    .rx_timeslot(rx_timeslot));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, {2'h0, idx, 2'h0}, 32'h0);
    chk(q, {24'h0, exp});
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, {2'h0, idx, 2'h0}, {24'h0, d});
  endtask : wr

  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n)
    begin
      ev <= m;
      @(posedge mclk);
      ev <= 4'h0;
      @(posedge mclk);
    end
  endtask : pulse

  task automatic sig(input logic [4:0] ch, input logic [3:0] b);
    sig_channel <= ch;
    sig_bits    <= b;
    sig_valid   <= 1'b1;
    @(posedge mclk);
    sig_valid <= 1'b0;
    @(posedge mclk);
  endtask : sig

  task automatic mon(input logic [4:0] ts, input logic [7:0] pat);
    for (int i = 0; i < 8; i++)
    begin
      rx_timeslot  <= ts;
      rx_bit_index <= 3'(i);
      rx_bit       <= pat[7-i];
      rx_bit_valid <= 1'b1;
      @(posedge mclk);
    end
    rx_bit_valid <= 1'b0;
    @(posedge mclk);
  endtask : mon

  // irq is decoded from the status and enable registers, so let them settle
  task automatic chk_irq(input logic exp);
    repeat (2)
      @(posedge mclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    {psel, penable, pwrite, e1_mode, esf_mode, out_of_frame, sig_valid, rx_bit_valid, rx_bit} = '0;
    {paddr, pwdata, ev, sig_channel, sig_bits, rx_bit_index, rx_timeslot} = '0;
    sys_rst = 1'b1;
    repeat (3)
      @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int i = 8'h40; i < 8'h58; i++)
      rd(8'(i), 8'h00);
    rd(8'h60, 8'h00);
    rd(8'h61, FW_REV);
    wr(8'h61, 8'hff);
    rd(8'h61, FW_REV);
    $display("test reset values done");
    e1_mode <= 1'b1;
    pulse(4'he, 258);
    e1_mode <= 1'b0;
    pulse(4'ha, 33);
    pulse(4'h1, 2);
    rd(8'h50, 8'h01);
    rd(8'h51, 8'h23);
    rd(8'h52, 8'h01);
    rd(8'h53, 8'h02);
    rd(8'h56, 8'h01);
    rd(8'h57, 8'h02);
    rd(8'h55, 8'h00);
    wr(8'h51, 8'h00);
    rd(8'h51, 8'h23);
    $display("test counters done");
    wr(8'h73, 8'h10);
    e1_mode  <= 1'b1;
    esf_mode <= 1'b1;
    sig(5'h00, 4'h6);
    sig(5'h01, 4'ha);
    sig(5'h10, 4'h5);
    sig(5'h11, 4'hd);
    e1_mode  <= 1'b0;
    esf_mode <= 1'b0;
    sig(5'h02, 4'hb);
    // host reads the signaling bytes well inside one multiframe
    rd(8'h40, 8'h06);
    rd(8'h41, 8'ha5);
    rd(8'h42, 8'had);
    chk_irq(1'b1);
    rd(8'h71, 8'h10);
    wr(8'h72, 8'h10);
    rd(8'h71, 8'h00);
    chk_irq(1'b0);
    out_of_frame <= 1'b1;
    sig(5'h01, 4'h3);
    pulse(4'h1, 5);
    rd(8'h41, 8'ha5);
    rd(8'h55, 8'h05);
    rd(8'h71, 8'h20);
    chk_irq(1'b0);
    wr(8'h73, 8'h30);
    chk_irq(1'b1);
    rd(8'h73, 8'h30);
    wr(8'h72, 8'h20);
    chk_irq(1'b0);
    out_of_frame <= 1'b0;
    $display("test signaling and interrupts done");
    wr(8'h70, 8'h05);
    mon(5'h05, 8'hb4);
    mon(5'h06, 8'h3c);
    rd(8'h60, 8'hb4);
    rd(8'h70, 8'h05);
    xfer(1'b0, 12'h200, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 12'h142, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    xfer(1'b0, 12'hd40, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test monitor and errors done");
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(8'h51, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h60, 8'h00);
    chk_irq(1'b0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : rsec_top_test
`default_nettype wire
